// >>> rtl/cmpmx_pkg.sv
// Package for the comparator input mux control block.
// Assumes an 8-bit register map reached over Avalon-MM, word per register.
package cmpmx_pkg;
    // Printed register indices; byte address is four times the index
    localparam logic [7:0] IDX_PORT_LEVELS = 8'h05;
    localparam logic [7:0] IDX_CMP_CONTROL = 8'h1F;
    localparam logic [7:0] IDX_PORT_DIR = 8'h85;
    localparam logic [7:0] IDX_VREF_CONTROL = 8'h9F;
    localparam int ADDR_W = 10;
    // Reset values
    localparam logic [4:0] RST_PORT_DIR = 5'h1F;
    localparam logic [4:0] RST_PORT_LATCH = 5'h00;
    localparam logic [3:0] RST_CMP_CTRL = 4'h0;
    localparam logic [7:0] RST_VREF_CTRL = 8'h00;
    // Control register field positions
    localparam int POS_CMP2_RESULT = 7;
    localparam int POS_CMP1_RESULT = 6;
    localparam int POS_INPUT_SWITCH = 3;
    // Reference control: bit 4 unimplemented
    localparam logic [7:0] VREF_IMPL_MASK = 8'hEF;
    localparam int POS_VREF_OUT_EN = 6;
    // Comparator input source codes
    typedef enum logic [2:0] {
        CMPMX_SRC_PIN0,
        CMPMX_SRC_PIN1,
        CMPMX_SRC_PIN2,
        CMPMX_SRC_PIN3,
        CMPMX_SRC_VREF,
        CMPMX_SRC_NONE
    } cmpmx_src_t;
    localparam logic [2:0] MODE_ONE_SWITCHED = 3'h1;
    localparam logic [2:0] MODE_TWO_SWITCHED = 3'h2;
endpackage

// >>> rtl/cmpmx_route.sv
// Input routing decode for the two comparators.
// Assumes mode and switch come from registered control bits.
module cmpmx_route
    import cmpmx_pkg::*;
(
    // Control
    input wire logic [2:0] mode_i,
    input wire logic input_switch_i,
    // Selected sources
    output cmpmx_pkg::cmpmx_src_t cmp1_neg_o,
    output cmpmx_pkg::cmpmx_src_t cmp2_neg_o,
    output cmpmx_pkg::cmpmx_src_t cmp1_pos_o,
    output cmpmx_pkg::cmpmx_src_t cmp2_pos_o
);
    wire mode1 = (mode_i == MODE_ONE_SWITCHED);
    wire mode2 = (mode_i == MODE_TWO_SWITCHED);
    // Switch acts only in the two defined modes
    assign cmp1_neg_o = (mode1 || mode2) ?
        (input_switch_i ? CMPMX_SRC_PIN3 : CMPMX_SRC_PIN0) : CMPMX_SRC_PIN0;
    assign cmp2_neg_o = mode2 ?
        (input_switch_i ? CMPMX_SRC_PIN2 : CMPMX_SRC_PIN1) : CMPMX_SRC_PIN1;
    // Non-inverting inputs: reference in mode 2, pins otherwise
    assign cmp1_pos_o = mode2 ? CMPMX_SRC_VREF : CMPMX_SRC_PIN3;
    assign cmp2_pos_o = mode2 ? CMPMX_SRC_VREF : CMPMX_SRC_PIN2;
endmodule

// >>> rtl/cmpmx_top.sv
// Comparator input mux control and port A pin routing.
// Assumes analog comparator results arrive asynchronously; pins via I/O pads.
module cmpmx_top
    import cmpmx_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [cmpmx_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Analog comparator results
    input wire logic cmp1_raw_i,
    input wire logic cmp2_raw_i,
    // Port pins 0..4
    input wire logic [4:0] port_pin_i,
    output logic [4:0] port_pin_o,
    output logic [4:0] port_pin_oe_o,
    // Analog mux selects
    output cmpmx_pkg::cmpmx_src_t cmp1_neg_sel_o,
    output cmpmx_pkg::cmpmx_src_t cmp2_neg_sel_o,
    output cmpmx_pkg::cmpmx_src_t cmp1_pos_sel_o,
    output cmpmx_pkg::cmpmx_src_t cmp2_pos_sel_o,
    // Reference output and timer clock
    output logic vref_pin_en_o,
    output logic [7:0] vref_control_o,
    output logic timer_ext_clock_in_o
);
    logic rst_s1;
    logic rst_n;
    logic [1:0] cmp_meta;
    logic [1:0] cmp_sync;
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic [4:0] port_latch;
    logic [4:0] port_direction;
    logic input_switch;
    logic [2:0] cmp_mode_field;
    logic [7:0] vref_control;
    logic [1:0] cmp_result;
    logic ack;
    logic [31:0] rdata;

    // Reset release through two flip-flops
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Synchronise comparator results and pins
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmp_meta <= 2'h0;
            cmp_sync <= 2'h0;
            pin_meta <= 5'h00;
            pin_sync <= 5'h00;
        end else begin
            cmp_meta <= {cmp2_raw_i, cmp1_raw_i};
            cmp_sync <= cmp_meta;
            pin_meta <= port_pin_i;
            pin_sync <= pin_meta;
        end
    end

    // Comparator results: gated off while comparators are reset-mode 000
    wire cmp_off = (cmp_mode_field == 3'h0);
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmp_result <= 2'h0;
        end else begin
            cmp_result <= cmp_off ? 2'h0 : cmp_sync;
        end
    end

    // Bus decode
    wire [7:0] reg_idx = avs_address_i[ADDR_W-1:2];
    wire hit_port = (reg_idx == IDX_PORT_LEVELS);
    wire hit_cmp = (reg_idx == IDX_CMP_CONTROL);
    wire hit_dir = (reg_idx == IDX_PORT_DIR);
    wire hit_vref = (reg_idx == IDX_VREF_CONTROL);
    wire req = (avs_read_i || avs_write_i) && !ack;
    wire wr_lane0 = avs_write_i && !ack && avs_byteenable_i[0];
    wire [7:0] wd = avs_writedata_i[7:0];

    // Control register image: bits 5-4 read zero
    wire [7:0] cmp_image = {cmp_result[1], cmp_result[0], 2'b00, input_switch,
        cmp_mode_field};
    // Port read returns pin levels, upper bits zero
    wire [7:0] port_image = {3'b000, pin_sync};
    wire [7:0] dir_image = {3'b000, port_direction};
    wire [7:0] vref_image = vref_control & VREF_IMPL_MASK;
    wire [7:0] read_mux = hit_port ? port_image :
                          hit_cmp ? cmp_image :
                          hit_dir ? dir_image :
                          hit_vref ? vref_image : 8'h00;

    // One wait cycle per access, then acknowledge
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ack <= req;
            if (req && avs_read_i) begin
                rdata <= {24'h00_0000, read_mux};
            end
        end
    end
    assign avs_readdata_o = rdata;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !req;
        end
    end

    // Writable registers
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            port_latch <= RST_PORT_LATCH;
            port_direction <= RST_PORT_DIR;
            input_switch <= RST_CMP_CTRL[POS_INPUT_SWITCH];
            cmp_mode_field <= RST_CMP_CTRL[2:0];
            vref_control <= RST_VREF_CTRL;
        end else if (wr_lane0) begin
            if (hit_port) begin
                port_latch <= wd[4:0];
            end
            if (hit_dir) begin
                port_direction <= wd[4:0];
            end
            if (hit_cmp) begin
                input_switch <= wd[POS_INPUT_SWITCH];
                cmp_mode_field <= wd[2:0];
            end
            if (hit_vref) begin
                vref_control <= wd & VREF_IMPL_MASK;
            end
        end
    end

    // Comparator input routing
    cmpmx_pkg::cmpmx_src_t c1n;
    cmpmx_pkg::cmpmx_src_t c2n;
    cmpmx_pkg::cmpmx_src_t c1p;
    cmpmx_pkg::cmpmx_src_t c2p;
    cmpmx_route u_route (
        .mode_i(cmp_mode_field),
        .input_switch_i(input_switch),
        .cmp1_neg_o(c1n),
        .cmp2_neg_o(c2n),
        .cmp1_pos_o(c1p),
        .cmp2_pos_o(c2p)
    );

    // Pin function selection
    wire cmp_out_mode = (cmp_mode_field == 3'h6); // Comparator outputs on pins
    wire vref_out = vref_control[POS_VREF_OUT_EN];
    wire [4:0] next_pin_o = {
        cmp_out_mode ? 1'b0 : port_latch[4], // open-drain drives only low
        cmp_out_mode ? cmp_result[0] : port_latch[3],
        port_latch[2:0]
    };
    wire pin4_drive = cmp_out_mode ? !cmp_result[1] :
        (!port_direction[4] && !port_latch[4]);
    wire pin3_drive = cmp_out_mode || !port_direction[3];
    wire pin2_drive = !port_direction[2] && !vref_out;
    wire [4:0] next_pin_oe = {pin4_drive, pin3_drive, pin2_drive,
        ~port_direction[1:0]};

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            port_pin_o <= 5'h00;
            port_pin_oe_o <= 5'h00;
            cmp1_neg_sel_o <= CMPMX_SRC_PIN0;
            cmp2_neg_sel_o <= CMPMX_SRC_PIN1;
            cmp1_pos_sel_o <= CMPMX_SRC_PIN3;
            cmp2_pos_sel_o <= CMPMX_SRC_PIN2;
            vref_pin_en_o <= 1'b0;
            vref_control_o <= RST_VREF_CTRL;
            timer_ext_clock_in_o <= 1'b0;
        end else begin
            port_pin_o <= next_pin_o;
            port_pin_oe_o <= next_pin_oe;
            cmp1_neg_sel_o <= c1n;
            cmp2_neg_sel_o <= c2n;
            cmp1_pos_sel_o <= c1p;
            cmp2_pos_sel_o <= c2p;
            vref_pin_en_o <= vref_out;
            vref_control_o <= vref_control;
            timer_ext_clock_in_o <= pin_sync[4];
        end
    end
endmodule

// >>> verif/cmpmx_assertions.sv
// Concurrent checks on the comparator mux control ports.
// Assumes a bind onto cmpmx_top; one clock domain.
module cmpmx_assertions
    import cmpmx_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [cmpmx_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [4:0] port_pin_o,
    input wire logic [4:0] port_pin_oe_o,
    input wire cmpmx_pkg::cmpmx_src_t cmp1_neg_sel_o,
    input wire cmpmx_pkg::cmpmx_src_t cmp2_neg_sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [2:0] sh_mode;
    logic sh_sw;
    logic [1:0] settle;
    wire ctrl_wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
        && avs_address_i == 10'h07C;
    wire settled = settle[1];
    wire ctrl_rd = avs_read_i && !avs_waitrequest_o && avs_address_i == 10'h07C;
    // Shadow of mode and switch, with time since last change
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sh_mode <= 3'h0;
            sh_sw <= 1'b0;
            settle <= 2'h0;
        end else if (ctrl_wr) begin
            sh_mode <= avs_writedata_i[2:0];
            sh_sw <= avs_writedata_i[3];
            settle <= 2'h0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end
    end
    a_ack_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for two cycles");
    a_ack_prompt: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered next cycle");
    a_ack_needs_req: assert property (!avs_waitrequest_o |-> avs_read_i || avs_write_i)
        else $error("answer without request");
    a_upper_zero: assert property (ctrl_rd |-> avs_readdata_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_ctrl_gap_zero: assert property (ctrl_rd |-> avs_readdata_o[5:4] == 2'h0)
        else $error("control bits 5:4 not zero");
    a_mode1_route: assert property (settled && sh_mode == 3'h1 |-> cmp1_neg_sel_o ==
        (sh_sw ? CMPMX_SRC_PIN3 : CMPMX_SRC_PIN0)) else $error("mode 1 routing wrong");
    a_mode2_route: assert property (settled && sh_mode == 3'h2 |->
        cmp1_neg_sel_o == (sh_sw ? CMPMX_SRC_PIN3 : CMPMX_SRC_PIN0) &&
        cmp2_neg_sel_o == (sh_sw ? CMPMX_SRC_PIN2 : CMPMX_SRC_PIN1))
        else $error("mode 2 routing wrong");
    a_other_fixed: assert property (settled && !(sh_mode inside {3'h1, 3'h2}) |->
        cmp1_neg_sel_o == CMPMX_SRC_PIN0 && cmp2_neg_sel_o == CMPMX_SRC_PIN1)
        else $error("switch changed routing in other mode");
    a_pin4_drain: assert property (port_pin_oe_o[4] |-> !port_pin_o[4])
        else $error("pin 4 driven high");
    c_ctrl_write: cover property (ctrl_wr);
    c_mode2_sw: cover property (settled && sh_mode == 3'h2 && sh_sw);
    c_pin4_low: cover property (port_pin_oe_o[4]);
endmodule

// >>> verif/cmpmx_top_tb.sv
// Self-checking bench for cmpmx_top through its Avalon-MM port.
// Assumes the package and checker are compiled before this file.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module cmpmx_top_tb;
    import cmpmx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i, rst_n_i, avs_read_i, avs_write_i, cmp1_raw_i, cmp2_raw_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0] avs_byteenable_i;
    logic avs_waitrequest_o, vref_pin_en_o, timer_ext_clock_in_o;
    logic [4:0] port_pin_i, port_pin_o, port_pin_oe_o;
    logic [7:0] vref_control_o, q;
    cmpmx_src_t cmp1_neg_sel_o, cmp2_neg_sel_o, cmp1_pos_sel_o, cmp2_pos_sel_o;
    int failures = 0, checks_done = 0, cyc = 0;
    cmpmx_top u_cmpmx_top (.*);
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            conclude();
        end
    end
    task automatic conclude();
        $display("failures=%0d checks_done=%0d", failures, checks_done);
        if (failures == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask
    // One bus access; read data lands in q
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                       input logic [3:0] be = 4'hF);
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_writedata_i <= {24'h0, d};
        avs_byteenable_i <= be;
        do begin
            @(posedge core_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o[7:0];
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic t_reset_values();
        bus(0, 10'h07C, 8'h00);
        `CHK(q, 8'h00)
        bus(0, 10'h214, 8'h00);
        `CHK(q, 8'h1F)
    endtask
    task automatic t_ctrl_fields();
        bus(1, 10'h07C, 8'hFF);
        bus(0, 10'h07C, 8'h00);
        `CHK(q, 8'h0F)
        bus(1, 10'h07C, 8'h00, 4'hE);
        bus(0, 10'h07C, 8'h00);
        `CHK(q, 8'h0F)
        bus(1, 10'h3F0, 8'hFF);
        bus(0, 10'h3F0, 8'h00);
        `CHK(q, 8'h00)
        bus(1, 10'h27C, 8'hFF);
        bus(0, 10'h27C, 8'h00);
        `CHK(q, 8'hEF)
        bus(1, 10'h27C, 8'h00);
    endtask
    task automatic t_results();
        bus(1, 10'h07C, 8'h02);
        cmp1_raw_i <= 1'b1;
        idle(5);
        bus(0, 10'h07C, 8'h00);
        `CHK(q, 8'h42)
        cmp1_raw_i <= 1'b0;
        cmp2_raw_i <= 1'b1;
        idle(5);
        bus(0, 10'h07C, 8'h00);
        `CHK(q, 8'h82)
        bus(1, 10'h07C, 8'h00);
        idle(5);
        bus(0, 10'h07C, 8'h00);
        `CHK(q, 8'h00)
    endtask
    task automatic t_route();
        for (int i = 0; i < 16; i++) begin
            logic [2:0] m;
            logic s;
            cmpmx_src_t e1;
            cmpmx_src_t e2;
            m = i[2:0];
            s = i[3];
            e1 = (m inside {3'h1, 3'h2}) && s ? CMPMX_SRC_PIN3 : CMPMX_SRC_PIN0;
            e2 = (m == 3'h2) && s ? CMPMX_SRC_PIN2 : CMPMX_SRC_PIN1;
            bus(1, 10'h07C, 8'(i));
            idle(4);
            `CHK(cmp1_neg_sel_o, e1)
            if (m != 3'h1) `CHK(cmp2_neg_sel_o, e2)
            e1 = (m == 3'h2) ? CMPMX_SRC_VREF : CMPMX_SRC_PIN3;
            e2 = (m == 3'h2) ? CMPMX_SRC_VREF : CMPMX_SRC_PIN2;
            `CHK(cmp1_pos_sel_o, e1)
            `CHK(cmp2_pos_sel_o, e2)
        end
        bus(1, 10'h07C, 8'h00);
    endtask
    task automatic t_pins();
        bus(0, 10'h014, 8'h00);
        `CHK(q, 8'h15)
        bus(1, 10'h214, 8'h00);
        bus(1, 10'h014, 8'h00);
        idle(2);
        `CHK(port_pin_oe_o, 5'h1F)
        bus(1, 10'h014, 8'h1F);
        idle(2);
        `CHK(port_pin_oe_o, 5'h0F)
        `CHK(port_pin_o[3:0], 4'hF)
        bus(1, 10'h27C, 8'h40);
        idle(2);
        `CHK(vref_pin_en_o, 1'b1)
        `CHK(port_pin_oe_o[2], 1'b0)
        `CHK(vref_control_o, 8'h40)
        `CHK(timer_ext_clock_in_o, 1'b1)
        port_pin_i <= 5'h0A;
        idle(4);
        `CHK(timer_ext_clock_in_o, 1'b0)
        bus(0, 10'h014, 8'h00);
        `CHK(q, 8'h0A)
        cmp1_raw_i <= 1'b0;
        cmp2_raw_i <= 1'b0;
        bus(1, 10'h07C, 8'h06);
        idle(6);
        `CHK(port_pin_o[4:3], 2'b00)
        `CHK(port_pin_oe_o[4:3], 2'b11)
        cmp1_raw_i <= 1'b1;
        cmp2_raw_i <= 1'b1;
        idle(6);
        `CHK(port_pin_o[4:3], 2'b01)
        `CHK(port_pin_oe_o[4:3], 2'b01)
        bus(1, 10'h07C, 8'h00);
    endtask
    initial begin
        rst_n_i = 1'b0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = '0;
        avs_writedata_i = '0;
        avs_byteenable_i = 4'hF;
        cmp1_raw_i = 1'b0;
        cmp2_raw_i = 1'b0;
        port_pin_i = 5'h15;
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        idle(4);
        t_reset_values();
        t_ctrl_fields();
        t_results();
        t_route();
        t_pins();
        conclude();
    end
endmodule
bind cmpmx_top cmpmx_assertions u_cmpmx_assertions (.*);
